// ===== shared/scsi_host_defs.vh
`ifndef SCSI_HOST_DEFS_VH
`define SCSI_HOST_DEFS_VH

// Clock rate of the controller
`define CLK_MHZ 100

// Host-port timing, in ns; all are least times
`define ADDR_SETUP_NS 30
`define STROBE_NS 120
`define HOLD_NS 30
`define GAP_NS 60

// Least time in ns to whole clock cycles, rounded up
`define CYC_CEIL(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)

`define SETUP_CYC `CYC_CEIL(`ADDR_SETUP_NS)
`define STROBE_CYC `CYC_CEIL(`STROBE_NS)
`define HOLD_CYC `CYC_CEIL(`HOLD_NS)
`define GAP_CYC `CYC_CEIL(`GAP_NS)

// Device register offsets on reg_select_lines
`define REG_LIVE_BUS_DATA 3'h0
`define REG_OUTGOING_DATA 3'h0
`define REG_INITIATOR_CONTROL 3'h1
`define REG_OPERATING_CONTROL 3'h2
`define REG_TARGET_PHASE_CONTROL 3'h3
`define REG_BUS_SIGNAL_STATUS 3'h4
`define REG_SELECTION_ID_MATCH 3'h4
`define REG_BUS_AND_FLAGS_STATUS 3'h5
`define REG_DMA_SEND_TRIGGER 3'h5
`define REG_LATCHED_INCOMING_DATA 3'h6
`define REG_DMA_TARGET_RX_TRIGGER 3'h6
`define REG_PARITY_IRQ_CLEAR 3'h7
`define REG_DMA_INITIATOR_RX_TRIGGER 3'h7

// Field positions in operating_control
`define OPCTL_DMA_ENABLE_BIT 1
`define OPCTL_TARGET_ROLE_BIT 6

// Reset values of the controller's own state
`define DATA_RESET 8'h00
`define COUNT_RESET 16'h0000

`endif

// ===== verilog/pin_sync.v
`timescale 1ns/100ps
// Two-flop synchroniser for pins that arrive from outside the clock domain
module pin_sync #(
  parameter WIDTH = 11
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Asynchronous inputs and synchronised outputs
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;

  // The first stage feeds nothing but the second
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule // pin_sync

// ===== verilog/two_entry_buffer.v
`timescale 1ns/100ps
// Two-entry byte buffer with valid/ready on both sides
module two_entry_buffer (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Filling side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [7:0] in_data_i,
  // Draining side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [7:0] out_data_o
);

  reg [7:0] mem [0:1];
  reg wr_idx;
  reg rd_idx;
  reg [1:0] fill;

  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (fill != 2'd2);
  assign out_valid_o = (fill != 2'd0);
  assign out_data_o = mem[rd_idx];

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      fill <= 2'd0;
    end else begin
      if (push) begin
        mem[wr_idx] <= in_data_i;
        wr_idx <= ~wr_idx;
      end
      if (pop) begin
        rd_idx <= ~rd_idx;
      end
      if (push && !pop) begin
        fill <= fill + 2'd1;
      end else if (pop && !push) begin
        fill <= fill - 2'd1;
      end
    end
  end

endmodule // two_entry_buffer

// ===== verilog/scsi_host_ctrl.v
`timescale 1ns/100ps
`include "scsi_host_defs.vh"

module scsi_host_ctrl (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Register access orders
  input wire cmd_valid_i,
  output wire cmd_ready_o,
  input wire cmd_write_i,
  input wire [2:0] cmd_addr_i,
  input wire [7:0] cmd_wdata_i,
  output reg rsp_valid_o,
  output reg [7:0] rsp_data_o,
  // DMA orders
  input wire dma_start_i,
  input wire dma_to_device_i,
  input wire [15:0] dma_count_i,
  input wire block_mode_i,
  output reg dma_busy_o,
  output reg dma_done_o,
  // Bytes toward the device
  input wire tx_valid_i,
  output wire tx_ready_o,
  input wire [7:0] tx_data_i,
  // Bytes from the device
  output wire rx_valid_o,
  input wire rx_ready_i,
  output wire [7:0] rx_data_o,
  // Device interrupt, synchronised
  output wire irq_o,
  // Device host port
  output reg chip_select_n_o,
  output reg [2:0] reg_select_lines_o,
  output reg host_read_n_o,
  output reg host_write_n_o,
  input wire [7:0] host_data_bus_i,
  output reg [7:0] host_data_bus_o,
  output reg host_data_bus_oe_o,
  output reg dma_ack_n_o,
  output reg end_of_transfer_n_o,
  input wire dma_request_i,
  input wire ready_i,
  input wire irq_i
);

  localparam ST_IDLE = 3'd0;
  localparam ST_SETUP = 3'd1;
  localparam ST_STROBE = 3'd2;
  localparam ST_HOLD = 3'd3;
  localparam ST_GAP = 3'd4;

  // The timing macros are 32-bit sums; cut them to the timer's width on purpose
  localparam integer SETUP_INT = `SETUP_CYC;
  localparam integer STROBE_INT = `STROBE_CYC;
  localparam integer HOLD_INT = `HOLD_CYC;
  localparam integer GAP_INT = `GAP_CYC;
  localparam [3:0] SETUP_CNT = SETUP_INT[3:0];
  localparam [3:0] STROBE_CNT = STROBE_INT[3:0];
  localparam [3:0] HOLD_CNT = HOLD_INT[3:0];
  localparam [3:0] GAP_CNT = GAP_INT[3:0];

  reg [2:0] state;
  reg [3:0] timer;
  reg is_dma;
  reg is_write;
  reg dma_dir;
  reg [15:0] dma_left;

  wire [10:0] pins_s;
  wire [7:0] data_s;
  wire drq_s;
  wire ready_s;
  wire irq_s;

  wire txq_valid;
  wire [7:0] txq_data;
  wire txq_pop;
  wire rxq_ready;
  wire rxq_push;
  wire dma_go;
  wire timer_end;

  // Device outputs and read data are asynchronous to our clock
  pin_sync #(
    .WIDTH(11)
  ) u_pin_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i({irq_i, ready_i, dma_request_i, host_data_bus_i}),
    .sync_o(pins_s)
  );

  assign data_s = pins_s[7:0];
  assign drq_s = pins_s[8];
  assign ready_s = pins_s[9];
  assign irq_s = pins_s[10];
  assign irq_o = irq_s;

  two_entry_buffer u_tx_buffer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(txq_valid),
    .out_ready_i(txq_pop),
    .out_data_o(txq_data)
  );

  two_entry_buffer u_rx_buffer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rxq_push),
    .in_ready_o(rxq_ready),
    .in_data_i(data_s),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o)
  );

  assign timer_end = (timer == 4'd1);

  // Register orders win over DMA; both start only from idle, so the two selects never overlap
  assign cmd_ready_o = (state == ST_IDLE);

  // A byte moves only on request, in block mode also on ready, and with a byte in the send buffer or room in the receive buffer
  assign dma_go = dma_busy_o && drq_s && (!block_mode_i || ready_s) &&
                  (dma_dir ? txq_valid : rxq_ready);

  assign txq_pop = (state == ST_IDLE) && !cmd_valid_i && dma_go && dma_dir;

  // Read data is sampled on the last strobe cycle, long after the sync delay has settled
  assign rxq_push = (state == ST_STROBE) && timer_end && is_dma && !is_write;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      timer <= 4'd0;
      is_dma <= 1'b0;
      is_write <= 1'b0;
      dma_dir <= 1'b0;
      dma_left <= `COUNT_RESET;
      dma_busy_o <= 1'b0;
      dma_done_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= `DATA_RESET;
      chip_select_n_o <= 1'b1;
      reg_select_lines_o <= 3'h0;
      host_read_n_o <= 1'b1;
      host_write_n_o <= 1'b1;
      host_data_bus_o <= `DATA_RESET;
      host_data_bus_oe_o <= 1'b0;
      dma_ack_n_o <= 1'b1;
      end_of_transfer_n_o <= 1'b1;
    end else begin
      rsp_valid_o <= 1'b0;
      dma_done_o <= 1'b0;

      // A zero count starts nothing; a start while busy is ignored
      if (!dma_busy_o && dma_start_i && (dma_count_i != 16'h0000)) begin
        dma_busy_o <= 1'b1;
        dma_left <= dma_count_i;
        dma_dir <= dma_to_device_i;
      end

      case (state)
        ST_IDLE: begin
          if (cmd_valid_i) begin
            is_dma <= 1'b0;
            is_write <= cmd_write_i;
            // Bus phase, handshake and attention lines are set by the register writes sent here
            reg_select_lines_o <= cmd_addr_i;
            chip_select_n_o <= 1'b0;
            host_data_bus_o <= cmd_wdata_i;
            host_data_bus_oe_o <= cmd_write_i;
            timer <= SETUP_CNT;
            state <= ST_SETUP;
          end else if (dma_go) begin
            is_dma <= 1'b1;
            is_write <= dma_dir;
            // Acknowledge with select high steers the strobe to a data register
            dma_ack_n_o <= 1'b0;
            // The last byte carries end-of-process so no further request follows
            end_of_transfer_n_o <= (dma_left != 16'h0001);
            host_data_bus_o <= txq_data;
            host_data_bus_oe_o <= dma_dir;
            timer <= SETUP_CNT;
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          timer <= timer - 4'd1;
          if (timer_end) begin
            host_read_n_o <= is_write;
            host_write_n_o <= !is_write;
            timer <= STROBE_CNT;
            state <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          timer <= timer - 4'd1;
          if (timer_end) begin
            if (!is_dma && !is_write) begin
              rsp_data_o <= data_s;
            end
            host_read_n_o <= 1'b1;
            host_write_n_o <= 1'b1;
            timer <= HOLD_CNT;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          timer <= timer - 4'd1;
          if (timer_end) begin
            chip_select_n_o <= 1'b1;
            dma_ack_n_o <= 1'b1;
            end_of_transfer_n_o <= 1'b1;
            host_data_bus_oe_o <= 1'b0;
            if (is_dma) begin
              // The byte counts as done when its acknowledge is released at the end of the hold
              dma_left <= dma_left - 16'h0001;
              if (dma_left == 16'h0001) begin
                dma_busy_o <= 1'b0;
                dma_done_o <= 1'b1;
              end
            end else begin
              rsp_valid_o <= 1'b1;
            end
            timer <= GAP_CNT;
            state <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Gives the request time to drop and pass the synchroniser before it is looked at again
          timer <= timer - 4'd1;
          if (timer_end) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          timer <= 4'd0;
        end
      endcase
    end
  end

endmodule // scsi_host_ctrl

// ===== tb/scsi_host_ctrl_asserts.sv
`timescale 1ns/100ps
module scsi_host_ctrl_checker (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Order port
  input wire cmd_valid_i,
  input wire cmd_ready_o,
  input wire rsp_valid_o,
  input wire dma_busy_o,
  input wire dma_done_o,
  // Device pins
  input wire chip_select_n_o,
  input wire host_read_n_o,
  input wire host_write_n_o,
  input wire host_data_bus_oe_o,
  input wire dma_ack_n_o,
  input wire end_of_transfer_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence setup_s;
    (host_read_n_o && host_write_n_o)[*3];
  endsequence
  sequence low12_s(logic s);
    (!s)[*8] ##1 (!s)[*4] ##1 s;
  endsequence
  cs_dma_ack_n_excl_a: assert property (chip_select_n_o || dma_ack_n_o)
    else $error("select and acknowledge low together");
  rsp_time_a: assert property (cmd_valid_i && cmd_ready_o |-> ##19 rsp_valid_o)
    else $error("register answer late or early");
  rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("answer longer than one cycle");
  addr_setup_a: assert property ($fell(chip_select_n_o) || $fell(dma_ack_n_o) |->
    setup_s ##1 (!host_read_n_o || !host_write_n_o)) else $error("strobe setup wrong");
  rd_width_a: assert property ($fell(host_read_n_o) |-> low12_s(host_read_n_o))
    else $error("read strobe width wrong");
  wr_width_a: assert property ($fell(host_write_n_o) |-> low12_s(host_write_n_o))
    else $error("write strobe width wrong");
  strobe_excl_a: assert property (host_read_n_o || host_write_n_o)
    else $error("both strobes low");
  eop_in_dma_a: assert property (!end_of_transfer_n_o |-> !dma_ack_n_o)
    else $error("end of transfer outside a byte");
  done_busy_a: assert property (dma_done_o |-> !dma_busy_o && $past(dma_busy_o))
    else $error("done without busy ending");
  drive_sel_a: assert property (host_data_bus_oe_o |->
    (!chip_select_n_o || !dma_ack_n_o) && host_read_n_o) else $error("bus driven outside write");
endmodule // scsi_host_ctrl_checker

bind scsi_host_ctrl scsi_host_ctrl_checker checker_i (.clock_i, .rst_n_i, .cmd_valid_i,
  .cmd_ready_o, .rsp_valid_o, .dma_busy_o, .dma_done_o, .chip_select_n_o, .host_read_n_o,
  .host_write_n_o, .host_data_bus_oe_o, .dma_ack_n_o, .end_of_transfer_n_o);

// ===== tb/scsi_dev_model.sv
`timescale 1ns/100ps
module scsi_dev_model #(
  parameter DLY = 200
) (
  // Reset
  input wire logic rst_n_i,
  // Host port
  input wire logic cs_n_i,
  input wire logic [2:0] a_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic ack_n_i,
  input wire logic eop_n_i,
  input wire logic [7:0] d_i,
  output logic [7:0] d_o,
  output logic drq_o,
  output logic rdy_o,
  output logic irq_o
);
  logic [7:0] r [0:7];
  logic [7:0] log_b [0:3];
  logic [7:0] last;
  logic eop_seen;
  logic par_bad;
  int n_in;
  int n_out;
  wire sel_rd = !rd_n_i && (!cs_n_i || !ack_n_i);
  wire [7:0] rv = !cs_n_i ? (a_i == 3'h7 ? {6'h00, par_bad, irq_o} : r[a_i])
                          : 8'h40 + n_in[7:0];
  // Released bus shows the inverse of its last value, never a stale match
  assign d_o = sel_rd ? rv : ~last;
  assign rdy_o = !r[2][1] || drq_o;
  // Bus side: the device only pulls lines low; the role decides which controls it may pull
  wire tgt = r[2][6];
  wire [7:0] db_n = ~((r[1][0] || r[2][0]) ? r[0] : 8'h00);
  wire dbp_n = ^(~db_n);
  wire [5:0] ctl_n = {~(r[1][4] & ~tgt), ~(r[1][1] & ~tgt),
                      ~(r[3][3:0] & {4{tgt}})};
  initial begin
    r[4] = 8'hc3;
    r[5] = 8'h3c;
    r[6] = 8'h00;
    r[7] = 8'h00;
  end
  // Reset is level-checked at time zero too, since a low start gives no falling edge
  initial forever begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) r[i] = 8'h00;
      {drq_o, irq_o, eop_seen, par_bad, last} = 12'h000;
      n_in = 0;
      n_out = 0;
    end
    @(negedge rst_n_i);
  end
  // Live-data reads judge the lines as the read begins; a miss stays until cleared
  always @(negedge rd_n_i) begin
    if (!cs_n_i && a_i == 3'h0 && r[2][5] && !(^{~db_n, ~dbp_n})) par_bad <= 1'b1;
  end
  always @(posedge rd_n_i) begin
    last <= rv;
    if (!ack_n_i) n_in++;
    if (!cs_n_i && a_i == 3'h7) begin
      irq_o <= 1'b0;
      par_bad <= 1'b0;
    end
  end
  always @(posedge wr_n_i) begin
    if (!cs_n_i) begin
      if (a_i < 3'h4) r[a_i] <= d_i;
      if (a_i == 3'h2) begin
        eop_seen <= 1'b0;
        drq_o <= d_i[1];
      end
    end else if (!ack_n_i) begin
      log_b[n_out] <= d_i;
      r[0] <= d_i;
      n_out++;
    end
  end
  always @(posedge rd_n_i or posedge wr_n_i) begin
    if (!ack_n_i && !eop_n_i) begin
      eop_seen = 1'b1;
      irq_o = r[2][3];
    end
  end
  always @(negedge ack_n_i) drq_o = 1'b0;
  always @(posedge ack_n_i) begin
    #(DLY) drq_o = r[2][1] && !eop_seen;
  end
endmodule // scsi_dev_model

// ===== tb/scsi_host_ctrl_bench.sv
`timescale 1ns/100ps
module scsi_host_ctrl_bench;
  logic clock_i = 0, rst_n_i = 0, cmd_valid_i = 0, cmd_write_i = 0, dma_start_i = 0;
  logic dma_to_device_i = 0, block_mode_i = 0, tx_valid_i = 0, rx_ready_i = 0;
  logic [2:0] cmd_addr_i = 3'h0;
  logic [7:0] cmd_wdata_i = 8'h00, tx_data_i = 8'h00, host_data_bus_i, dev_d;
  logic [15:0] dma_count_i = 16'h0000;
  logic dma_request_i, ready_i, irq_i, cmd_ready_o, rsp_valid_o, dma_busy_o, dma_done_o;
  logic tx_ready_o, rx_valid_o, irq_o, chip_select_n_o, host_read_n_o, host_write_n_o;
  logic host_data_bus_oe_o, dma_ack_n_o, end_of_transfer_n_o;
  logic [7:0] rsp_data_o, rx_data_o, host_data_bus_o;
  logic [2:0] reg_select_lines_o;
  int n_errors = 0, checked = 0, cyc = 0, n_done = 0;
  scsi_host_ctrl scsi_host_ctrl_i (.*);
  scsi_dev_model scsi_dev_model_i (.rst_n_i, .cs_n_i(chip_select_n_o), .a_i(reg_select_lines_o),
    .rd_n_i(host_read_n_o), .wr_n_i(host_write_n_o), .ack_n_i(dma_ack_n_o),
    .eop_n_i(end_of_transfer_n_o), .d_i(host_data_bus_o), .d_o(dev_d), .drq_o(dma_request_i),
    .rdy_o(ready_i), .irq_o(irq_i));
  assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : dev_d;
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (dma_done_o === 1'b1) n_done++;
    if (cyc == 60000) begin
      n_errors++;
      end_sim;
    end
  end
  task end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task cmd(input logic w, input logic [2:0] a, input logic [7:0] d);
    int k;
    @(posedge clock_i);
    {cmd_valid_i, cmd_write_i, cmd_addr_i, cmd_wdata_i} <= {1'b1, w, a, d};
    do @(posedge clock_i); while (cmd_ready_o !== 1'b1);
    cmd_valid_i <= 1'b0;
    for (k = 0; k < 40 && rsp_valid_o !== 1'b1; k++) begin
      @(posedge clock_i);
      #1;
    end
    chk("rsp", 8'h01, {7'h00, rsp_valid_o});
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    cmd(1'b0, a, 8'h00);
    chk("read", e, rsp_data_o);
  endtask
  task start(input logic to_dev, input logic [15:0] n);
    @(posedge clock_i);
    {dma_start_i, dma_to_device_i, dma_count_i, block_mode_i} <= {1'b1, to_dev, n, to_dev};
    @(posedge clock_i);
    dma_start_i <= 1'b0;
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task t_regs;
    for (int a = 1; a < 4; a++) rd(a[2:0], 8'h00);
    for (int a = 1; a < 4; a++) begin
      cmd(1'b1, a[2:0], {a[3:0], 4'h4});
      rd(a[2:0], {a[3:0], 4'h4});
    end
    cmd(1'b1, 3'h0, 8'h5e);
    rd(3'h0, 8'h5e);
    rd(3'h4, 8'hc3);
    rd(3'h5, 8'h3c);
    chk("bus_ctl", 8'h1f, {2'b00, scsi_dev_model_i.ctl_n});
    chk("parity", 8'h00, {7'h00, scsi_dev_model_i.dbp_n});
  endtask
  task t_dma_rx;
    cmd(1'b1, 3'h2, 8'h0a);
    start(1'b0, 16'h0003);
    wait_cyc(400);
    chk("stalled", 8'h02, scsi_dev_model_i.n_in[7:0]);
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 500 && rx_valid_o !== 1'b1; k++) wait_cyc(1);
      chk("rx", 8'h40 + i[7:0], rx_data_o);
      @(posedge clock_i) rx_ready_i <= 1'b1;
      @(posedge clock_i) rx_ready_i <= 1'b0;
      #1;
    end
    wait_cyc(100);
    chk("done", 8'h01, n_done[7:0]);
    chk("no_req", 8'h00, {7'h00, dma_request_i});
    chk("irq", 8'h01, {7'h00, irq_o});
    rd(3'h7, 8'h01);
    wait_cyc(5);
    chk("irq_clr", 8'h00, {7'h00, irq_o});
  endtask
  task t_dma_tx;
    cmd(1'b1, 3'h2, 8'h02);
    @(posedge clock_i) {tx_valid_i, tx_data_i} <= {1'b1, 8'h3c};
    @(posedge clock_i) tx_data_i <= 8'ha5;
    @(posedge clock_i) tx_valid_i <= 1'b0;
    #1;
    chk("tx_full", 8'h00, {7'h00, tx_ready_o});
    start(1'b1, 16'h0002);
    wait_cyc(300);
    chk("done2", 8'h02, n_done[7:0]);
    chk("tx0", 8'h3c, scsi_dev_model_i.log_b[0]);
    chk("tx1", 8'ha5, scsi_dev_model_i.log_b[1]);
  endtask
  task t_dma_off;
    cmd(1'b1, 3'h2, 8'h00);
    start(1'b0, 16'h0001);
    wait_cyc(300);
    chk("busy", 8'h01, {7'h00, dma_busy_o});
    chk("no_rx", 8'h03, scsi_dev_model_i.n_in[7:0]);
    cmd(1'b1, 3'h2, 8'h02);
    wait_cyc(200);
    chk("done3", 8'h03, n_done[7:0]);
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_dma_rx;
    t_dma_tx;
    t_dma_off;
    end_sim;
  end
endmodule // scsi_host_ctrl_bench
